/* File: src/ums_pkg.sv */
`default_nettype none
package ums_pkg;
    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
    localparam logic [7:0] ADDR_EXT_FEAT = 8'h08;
    localparam logic [7:0] ADDR_MODEM_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_LINE_STAT = 8'h10;
    localparam logic [7:0] ADDR_MODEM_STAT = 8'h14;
    localparam logic [7:0] ADDR_FRAME_CFG = 8'h18;
    // ************************************************
    // field positions
    // ************************************************
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_AUX1 = 2;
    localparam int MC_IRQ_EN = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_XANY = 5;
    localparam int MC_IR = 6;
    localparam int MC_PRESC = 7;
    localparam int EF_ENH = 4;
    localparam int EF_AUTO_CTS = 7;
    localparam int EW_TX_DIS = 4;
    localparam int IE_RX = 0;
    localparam int IE_THR = 1;
    localparam int IE_LINE = 2;
    localparam int IE_MODEM = 3;
    localparam int FC_PAR_EN = 0;
    localparam int FC_PAR_EVEN = 1;
    localparam int FC_SW_FLOW = 2;
    // ************************************************
    // reset values and constants
    // ************************************************
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [7:0] EXT_FEAT_RST = 8'h00;
    localparam logic [7:0] EXTRA_WR_RST = 8'h00;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    localparam logic [2:0] FRAME_CFG_RST = 3'h0;
    localparam logic [5:0] SYNC_RST = 6'h3D;
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam logic [1:0] PRESC_LAST = 2'h3;
    localparam logic [3:0] TX_BITS_PAR = 4'hB;
    localparam logic [3:0] TX_BITS_NOPAR = 4'hA;
    localparam logic [2:0] RX_LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_DATA = 3'b001,
        RX_PAR = 3'b010,
        RX_STOP = 3'b011,
        RX_BRK = 3'b100
    } ums_rx_state_t;
endpackage : ums_pkg
`default_nettype wire

/* File: src/ums_modem_line_status.sv */
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`default_nettype none
module ums_modem_line_status
    import ums_pkg::*;
#(
    parameter int BAUD_DIV = 16,
    parameter int RX_DEPTH = 16
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial data
    input wire logic rx_i,
    input wire logic ir_rx_i,
    output logic tx_o,
    output logic ir_tx_o,
    // modem lines
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic ri_n_i,
    input wire logic cd_n_i,
    output logic rts_n_o,
    output logic dtr_n_o,
    // interrupt pin
    output logic irq_o,
    output logic irq_oe
);
    localparam int PW = $clog2(RX_DEPTH);
    localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);
    localparam logic [PW:0] DEPTH_W = (PW + 1)'(RX_DEPTH);

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [5:0] sync1_q, sync2_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else if (ce) begin
            sync1_q <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i, ir_rx_i, rx_i};
            sync2_q <= sync1_q;
        end
    end

    // ************************************************
    // bus slave
    // ************************************************
    logic [7:0] modem_ctrl_q, ext_feat_q, extra_wr_q;
    logic [3:0] irq_en_q;
    logic [2:0] frame_cfg_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic addr_ok, rd_now, wr_now;
    logic [7:0] rd_val, wdat;

    assign addr_ok = hsel & htrans[1] & hready;
    assign rd_now = ce & addr_ok & ~hwrite;
    assign wr_now = ce & wr_pend_q;
    assign wdat = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr[7:0];
            if (rd_now) begin
                hrdata_q <= {24'h00_0000, rd_val};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modem_ctrl_q <= MODEM_CTRL_RST;
            ext_feat_q <= EXT_FEAT_RST;
            extra_wr_q <= EXTRA_WR_RST;
            irq_en_q <= IRQ_EN_RST;
            frame_cfg_q <= FRAME_CFG_RST;
        end else if (wr_now) begin
            case (wr_addr_q)
                ADDR_MODEM_CTRL: begin
                    modem_ctrl_q[4:0] <= wdat[4:0];
                    if (ext_feat_q[EF_ENH]) begin
                        modem_ctrl_q[7:5] <= wdat[7:5];
                    end
                end
                ADDR_EXT_FEAT: ext_feat_q <= wdat;
                // lower half reserved, kept zero
                ADDR_MODEM_STAT: extra_wr_q <= {wdat[7:4], 4'h0};
                ADDR_IRQ_EN: irq_en_q <= wdat[3:0];
                ADDR_FRAME_CFG: frame_cfg_q <= wdat[2:0];
                default: ;
            endcase
        end
    end

    // ************************************************
    // modem status
    // ************************************************
    logic loop_en, aux_out_one, aux_out_two;
    logic [3:0] mstat, mstat_prev_q, delta_q, delta_set;
    logic msr_read;

    assign loop_en = modem_ctrl_q[MC_LOOP];
    assign aux_out_one = ~modem_ctrl_q[MC_AUX1];
    assign aux_out_two = ~modem_ctrl_q[MC_IRQ_EN];
    // order {cd, ri, dsr, cts}, active high
    assign mstat = loop_en ?
        {~aux_out_two, ~aux_out_one, modem_ctrl_q[MC_DTR],
         modem_ctrl_q[MC_RTS]} : ~sync2_q[5:2];
    // ring delta only when the pin rises, i.e. status falls
    assign delta_set = {mstat[3] ^ mstat_prev_q[3],
                        mstat_prev_q[2] & ~mstat[2],
                        mstat[1:0] ^ mstat_prev_q[1:0]};
    assign msr_read = rd_now & (haddr[7:0] == ADDR_MODEM_STAT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mstat_prev_q <= 4'h0;
            delta_q <= 4'h0;
        end else if (ce) begin
            mstat_prev_q <= mstat;
            // a change in the read cycle survives the clear
            delta_q <= (msr_read ? 4'h0 : delta_q) | delta_set;
        end
    end

    // ************************************************
    // baud tick with prescaler
    // ************************************************
    logic [1:0] presc_q;
    logic [15:0] div_q;
    logic pre_tick, tick;

    assign pre_tick = ~modem_ctrl_q[MC_PRESC] | (presc_q == PRESC_LAST);
    assign tick = pre_tick & (div_q == DIV_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= 2'h0;
            div_q <= 16'h0000;
        end else if (ce) begin
            presc_q <= modem_ctrl_q[MC_PRESC] ? presc_q + 2'h1 : 2'h0;
            if (pre_tick) begin
                div_q <= (div_q == DIV_LAST) ? 16'h0000 : div_q + 16'h0001;
            end
        end
    end

    // ************************************************
    // transmitter
    // ************************************************
    logic [7:0] thr_q;
    logic thr_full_q, tx_halt_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_left_q;
    logic tx_bit, tx_busy, tx_go, tx_par, thr_wr;

    assign thr_wr = wr_now & (wr_addr_q == ADDR_DATA);
    assign tx_busy = (tx_left_q != 4'h0);
    assign tx_bit = tx_busy ? tx_sh_q[0] : 1'b1;
    // checked only between characters, so a frame always completes
    assign tx_go = tick & ~tx_busy & thr_full_q & ~tx_halt_q
        & ~extra_wr_q[EW_TX_DIS]
        & ~(ext_feat_q[EF_AUTO_CTS] & ~mstat[0]);
    assign tx_par = frame_cfg_q[FC_PAR_EVEN] ? ^thr_q : ~^thr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr_q <= 8'h00;
            thr_full_q <= 1'b0;
            tx_sh_q <= 11'h7FF;
            tx_left_q <= 4'h0;
        end else if (ce) begin
            if (thr_wr) begin
                thr_q <= wdat;
                thr_full_q <= 1'b1;
            end else if (tx_go) begin
                thr_full_q <= 1'b0;
            end
            if (tx_go) begin
                tx_sh_q <= {1'b1, frame_cfg_q[FC_PAR_EN] ? tx_par : 1'b1,
                            thr_q, 1'b0};
                tx_left_q <= frame_cfg_q[FC_PAR_EN] ? TX_BITS_PAR
                                                    : TX_BITS_NOPAR;
            end else if (tick && tx_busy) begin
                tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                tx_left_q <= tx_left_q - 4'h1;
            end
        end
    end

    // ************************************************
    // receiver
    // ************************************************
    ums_rx_state_t rx_st_q;
    logic [7:0] rx_sh_q, rx_data_q;
    logic [2:0] rx_cnt_q, rx_tag_q;
    logic rx_par_q, rx_done_q, rx_line, rx_brk, rx_pe;

    assign rx_line = loop_en ? tx_bit
                   : (modem_ctrl_q[MC_IR] ? ~sync2_q[1] : sync2_q[0]);
    assign rx_brk = (rx_sh_q == 8'h00) & ~rx_line
                  & ~(frame_cfg_q[FC_PAR_EN] & rx_par_q);
    assign rx_pe = frame_cfg_q[FC_PAR_EN] & (rx_par_q !=
        (frame_cfg_q[FC_PAR_EVEN] ? ^rx_sh_q : ~^rx_sh_q));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_st_q <= RX_IDLE;
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 3'h0;
            rx_par_q <= 1'b0;
            rx_done_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_tag_q <= 3'h0;
        end else if (ce) begin
            rx_done_q <= 1'b0;
            if (tick) begin
                case (rx_st_q)
                    RX_IDLE: begin
                        if (!rx_line) begin
                            rx_st_q <= RX_DATA;
                            rx_cnt_q <= 3'h0;
                            rx_par_q <= 1'b0;
                        end
                    end
                    RX_DATA: begin
                        rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                        rx_cnt_q <= rx_cnt_q + 3'h1;
                        if (rx_cnt_q == RX_LAST_BIT) begin
                            rx_st_q <= frame_cfg_q[FC_PAR_EN] ? RX_PAR
                                                              : RX_STOP;
                        end
                    end
                    RX_PAR: begin
                        rx_par_q <= rx_line;
                        rx_st_q <= RX_STOP;
                    end
                    RX_STOP: begin
                        rx_done_q <= 1'b1;
                        rx_data_q <= rx_sh_q;
                        // tags {break, framing, parity}
                        rx_tag_q <= rx_brk ? 3'b100
                                  : {1'b0, ~rx_line, rx_pe};
                        // after a break, no new frame until the line is back high
                        rx_st_q <= rx_brk ? RX_BRK : RX_IDLE;
                    end
                    RX_BRK: begin
                        if (rx_line) begin
                            rx_st_q <= RX_IDLE;
                        end
                    end
                    default: rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end

    // ************************************************
    // software flow and resume-on-any
    // ************************************************
    logic is_xon, is_xoff, sw_flow, rx_store;

    assign sw_flow = frame_cfg_q[FC_SW_FLOW];
    assign is_xon = rx_data_q == XON_CHAR;
    assign is_xoff = rx_data_q == XOFF_CHAR;
    assign rx_store = rx_done_q & ~(sw_flow & (is_xon | is_xoff));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_halt_q <= 1'b0;
        end else if (ce && rx_done_q) begin
            if (sw_flow && is_xoff) begin
                tx_halt_q <= 1'b1;
            end else if ((sw_flow && is_xon) || modem_ctrl_q[MC_XANY]) begin
                tx_halt_q <= 1'b0;
            end
        end
    end

    // ************************************************
    // receive fifo and line status
    // ************************************************
    logic [7:0] rx_mem [RX_DEPTH];
    logic [2:0] tag_mem [RX_DEPTH];
    logic [RX_DEPTH-1:0] slot_err_q;
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] cnt_q;
    logic ovr_q, push, pop, full, data_rdy, thre, temt;
    logic [2:0] head_tag;
    logic [7:0] line_stat;

    assign full = (cnt_q == DEPTH_W);
    assign data_rdy = (cnt_q != '0);
    assign push = rx_store & ~full;
    assign pop = rd_now & (haddr[7:0] == ADDR_DATA) & data_rdy;
    assign head_tag = data_rdy ? tag_mem[rp_q] : 3'h0;
    assign thre = ~thr_full_q;
    assign temt = ~thr_full_q & ~tx_busy;
    assign line_stat = {|slot_err_q, temt, thre, head_tag,
                        ovr_q, data_rdy};

    always_ff @(posedge hclk) begin
        if (ce && push) begin
            rx_mem[wp_q] <= rx_data_q;
            tag_mem[wp_q] <= rx_tag_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            slot_err_q <= '0;
        end else if (ce) begin
            if (push) begin
                wp_q <= wp_q + PW'(1);
                slot_err_q[wp_q] <= |rx_tag_q;
            end
            if (pop) begin
                rp_q <= rp_q + PW'(1);
                if (!(push && wp_q == rp_q)) begin
                    slot_err_q[rp_q] <= 1'b0;
                end
            end
            // a full fifo keeps its count: the new character is lost
            cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovr_q <= 1'b0;
        end else if (ce) begin
            if (rx_store && full) begin
                ovr_q <= 1'b1;
            end else if (rd_now && haddr[7:0] == ADDR_LINE_STAT) begin
                ovr_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (haddr[7:0])
            ADDR_DATA: rd_val = data_rdy ? rx_mem[rp_q] : 8'h00;
            ADDR_IRQ_EN: rd_val = {4'h0, irq_en_q};
            ADDR_EXT_FEAT: rd_val = ext_feat_q;
            ADDR_MODEM_CTRL: rd_val = modem_ctrl_q;
            ADDR_LINE_STAT: rd_val = line_stat;
            ADDR_MODEM_STAT: rd_val = {mstat, delta_q};
            ADDR_FRAME_CFG: rd_val = {5'h00, frame_cfg_q};
            default: rd_val = 8'h00;
        endcase
    end

    // ************************************************
    // pins and interrupt
    // ************************************************
    logic irq_any;

    assign irq_any = (irq_en_q[IE_LINE] & (ovr_q | (|head_tag)))
                   | (irq_en_q[IE_MODEM] & (|delta_q))
                   | (irq_en_q[IE_RX] & data_rdy)
                   | (irq_en_q[IE_THR] & thre);
    assign irq_oe = modem_ctrl_q[MC_IRQ_EN];
    assign irq_o = irq_oe & irq_any;
    assign tx_o = loop_en | modem_ctrl_q[MC_IR] | tx_bit;
    assign ir_tx_o = ~loop_en & modem_ctrl_q[MC_IR] & ~tx_bit;
    assign rts_n_o = loop_en | ~modem_ctrl_q[MC_RTS];
    assign dtr_n_o = loop_en | ~modem_ctrl_q[MC_DTR];

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_mc_write_locked;
        wr_now && wr_addr_q == ADDR_MODEM_CTRL && !ext_feat_q[EF_ENH];
    endsequence
    sequence s_cts_blocked;
        ce && ext_feat_q[EF_AUTO_CTS] && !mstat[0] && !tx_busy;
    endsequence

    chk_rts_pin: assert property (!loop_en |-> rts_n_o == !modem_ctrl_q[1])
        else $error("rts pin does not follow control bit");
    chk_dtr_pin: assert property (!loop_en |-> dtr_n_o == !modem_ctrl_q[0])
        else $error("dtr pin does not follow control bit");
    chk_loop_quiet: assert property (loop_en |-> tx_o && rts_n_o && dtr_n_o)
        else $error("outputs active during loopback");
    chk_irq_tristate: assert property (!modem_ctrl_q[3] |-> !irq_oe && !irq_o)
        else $error("irq driven while disabled");
    chk_enh_lock: assert property (s_mc_write_locked |=>
        modem_ctrl_q[7:5] == $past(modem_ctrl_q[7:5]))
        else $error("locked control bits changed");
    chk_ovr_drop: assert property (ce && rx_store && full && !pop |=>
        ovr_q && cnt_q == $past(cnt_q))
        else $error("overrun not flagged or fifo altered");
    chk_loop_mirror: assert property (loop_en |->
        mstat == {modem_ctrl_q[3], modem_ctrl_q[2], modem_ctrl_q[0],
                  modem_ctrl_q[1]})
        else $error("loopback status mismatch");
    chk_ring_edge: assert property (ce && $rose(delta_q[2]) |->
        $past(mstat_prev_q[2]) && !$past(mstat[2]))
        else $error("ring delta without rising pin");
    chk_cts_halt: assert property (s_cts_blocked |=> !tx_busy)
        else $error("transmit started with cts high");
    chk_idle_flag: assert property (line_stat[6] |-> !tx_busy && line_stat[5])
        else $error("idle flag set while transmitting");
    chk_msr_clear: assert property (msr_read && delta_set == 4'h0 |=>
        delta_q == 4'h0)
        else $error("deltas not cleared by read");
    chk_break_once: assert property (ce && rx_done_q && rx_tag_q[2] |=>
        (rx_st_q == RX_BRK || rx_st_q == RX_IDLE) [*1] ##1 !rx_done_q)
        else $error("break repeated");
endmodule : ums_modem_line_status
`default_nettype wire

/* File: dv/ums_remote_model.sv */
`default_nettype none
module ums_remote_model (
    // bench control
    input wire logic [3:0] lvl_n,
    // uart lines
    input wire logic tx_i,
    output logic rx_o,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic ri_n_o,
    output logic cd_n_o,
    output logic [7:0] starts
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************
    // remote line behaviour
    // ************************************************
    // receive line has a pull-up here, so an idle line reads mark
    assign rx_o = 1'b1;
    assign {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} = lvl_n;
    // every start bit seen on the wire, so silence can be proven
    initial starts = 8'h00;
    always @(negedge tx_i) starts = starts + 8'h01;
endmodule : ums_remote_model
`default_nettype wire

/* File: dv/uart_modem_line_status_tb.sv */
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
 err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module uart_modem_line_status_tb import ums_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BDIV = 2;
    logic hclk, hresetn, hsel, hwrite, rd_vld, hreadyout, hresp;
    logic rx, tx_o, ir_tx_o, cts_n, dsr_n, ri_n, cd_n;
    logic rts_n_o, dtr_n_o, irq_o, irq_oe;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, lfsr;
    logic [3:0] lvl_n;
    logic [7:0] starts, exp_v;
    logic [7:0] exp_q[$];
    int err_total = 0;
    int checks_done = 0;
    ums_modem_line_status #(.BAUD_DIV(BDIV), .RX_DEPTH(16))
        i_ums_modem_line_status (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_i(rx), .ir_rx_i(1'b0),
        .tx_o(tx_o), .ir_tx_o(ir_tx_o), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
        .ri_n_i(ri_n), .cd_n_i(cd_n), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
        .irq_o(irq_o), .irq_oe(irq_oe));
    ums_remote_model i_ums_remote_model (.lvl_n(lvl_n), .tx_i(tx_o),
        .rx_o(rx), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n),
        .cd_n_o(cd_n), .starts(starts));
    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [7:0] e);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rd_vld <= !w;
        if (!w) exp_q.push_back(e);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_vld <= 1'b0;
    endtask : bus
    // ************************************************
    // clock, monitor, watchdog
    // ************************************************
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // read data settles one edge after the address phase
    always @(posedge hclk) begin
        if (rd_vld === 1'b1) begin
            // pop once: the compare macro names its expected value twice
            exp_v = exp_q.pop_front();
            `CHK("hrdata", {24'h0, exp_v}, hrdata)
        end
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        print_verdict();
    end
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, rd_vld, htrans, haddr, hwdata} = '0;
        lvl_n = 4'hF;
        lfsr = 32'h5CDEF417;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, ADDR_MODEM_CTRL, 8'h00, MODEM_CTRL_RST);
        bus(1'b0, ADDR_LINE_STAT, 8'h00, 8'h60);
        bus(1'b0, 8'h3C, 8'h00, 8'h00);
        bus(1'b1, ADDR_MODEM_CTRL, 8'hE3, 8'h00);
        bus(1'b0, ADDR_MODEM_CTRL, 8'h00, 8'h03);
        @(negedge hclk);
        `CHK("rts_n", 1'b0, rts_n_o)
        `CHK("dtr_n", 1'b0, dtr_n_o)
        `CHK("irq_oe", 1'b0, irq_oe)
        `CHK("irq", 1'b0, irq_o)
        @(posedge hclk);
        lvl_n <= 4'h0;
        repeat (4) @(posedge hclk);
        bus(1'b0, ADDR_MODEM_STAT, 8'h00, 8'hFB);
        bus(1'b0, ADDR_MODEM_STAT, 8'h00, 8'hF0);
        lvl_n <= 4'h4;
        repeat (4) @(posedge hclk);
        bus(1'b0, ADDR_MODEM_STAT, 8'h00, 8'hB4);
        bus(1'b1, ADDR_MODEM_CTRL, 8'h1F, 8'h00);
        @(negedge hclk);
        `CHK("rts_n", 1'b1, rts_n_o)
        `CHK("dtr_n", 1'b1, dtr_n_o)
        `CHK("irq_oe", 1'b1, irq_oe)
        `CHK("irq", 1'b0, irq_o)
        bus(1'b1, ADDR_IRQ_EN, 8'h02, 8'h00);
        @(negedge hclk);
        `CHK("irq", 1'b1, irq_o)
        bus(1'b0, ADDR_MODEM_STAT, 8'h00, 8'hF0);
        bus(1'b1, ADDR_DATA, 8'h5A, 8'h00);
        repeat (BDIV * 10 + 40) @(posedge hclk);
        bus(1'b0, ADDR_LINE_STAT, 8'h00, 8'h61);
        bus(1'b0, ADDR_DATA, 8'h00, 8'h5A);
        bus(1'b0, ADDR_LINE_STAT, 8'h00, 8'h60);
        `CHK("starts", 8'h00, starts)
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            bus(1'b1, ADDR_MODEM_CTRL, {6'h0, lfsr[1:0]}, 8'h00);
            @(negedge hclk);
            `CHK("rts_n", ~lfsr[1], rts_n_o)
            `CHK("dtr_n", ~lfsr[0], dtr_n_o)
        end
        bus(1'b1, ADDR_EXT_FEAT, 8'h10, 8'h00);
        bus(1'b1, ADDR_MODEM_CTRL, 8'hE0, 8'h00);
        bus(1'b0, ADDR_MODEM_CTRL, 8'h00, 8'hE0);
        @(negedge hclk);
        `CHK("ir_tx", 1'b0, ir_tx_o)
        `CHK("tx", 1'b1, tx_o)
        `CHK("irq", 1'b0, irq_o)
        // cts pin high with auto cts: the character must wait
        @(posedge hclk);
        lvl_n <= 4'h5;
        bus(1'b1, ADDR_EXT_FEAT, 8'h90, 8'h00);
        bus(1'b1, ADDR_DATA, 8'hA5, 8'h00);
        repeat (BDIV * 40 + 40) @(posedge hclk);
        bus(1'b0, ADDR_LINE_STAT, 8'h00, 8'h00);
        lvl_n <= 4'h4;
        // divide by four: still sending where an undivided frame is done
        repeat (BDIV * 10 + 30) @(posedge hclk);
        bus(1'b0, ADDR_LINE_STAT, 8'h00, 8'h20);
        repeat (BDIV * 40) @(posedge hclk);
        bus(1'b0, ADDR_LINE_STAT, 8'h00, 8'h60);
        print_verdict();
    end
endmodule : uart_modem_line_status_tb
`default_nettype wire
